// File: rtl/ctlc_pkg.sv
// Contract
// - Below 3.0V battery sense means pre-charge; at or above it means fast-charge.
// - Target voltage and charge current come from charge control register fields.
// - Charging starts on bus power with charger enable set, even in pre-charge range.
// - Charging ends above target minus 0.1V while current is below 10 percent.
// - Separate expiry timers for pre-charge and fast-charge, each with a two-bit field.
// - Pre-charge timer: 40, 50, 60, 70 minutes; resets to 01.
// - Fast-charge timer: 6, 8, 10, 12 hours; resets to 01.
// - Timer holds, not cleared, while current is below 20 percent.
// - On expiry enter safe mode at 5mA until above target minus 0.1V.
// - Leaving safe mode raises an interrupt event.
// - Read-only status bit shows safe mode.
// - Safe mode clears on source removal or charger enable toggle.
// - Selector bit: zero software drives indicator, one charger drives it.
// - Software field: Hi-Z, 25% 0.5Hz, 25% 2Hz, drive low.
// - Mode bit picks mapping A or B under charger control; resets zero.
// - Mapping A: idle Z, alarm 1Hz, overvoltage 4Hz, charging low.
// - Mapping B: no source Z, charging 1Hz, alarm 4Hz, full low.
// - Battery absent below 2.2V, present above it.
// - Every change of battery presence raises an event.
// - Presence is a status bit; a configuration bit enables detection.
// - With a source present, a detection probe pulse every 16 seconds.
package ctlc_pkg;

  // register indices; byte address is four times the index
  localparam logic [5:0] IDX_STATUS   = 6'h01;
  localparam logic [5:0] IDX_LED_DET  = 6'h32;
  localparam logic [5:0] IDX_CHG_CTRL = 6'h33;
  localparam logic [5:0] IDX_TMR_CFG  = 6'h34;

  // field positions
  localparam int STAT_PRESENT  = 5;
  localparam int STAT_SAFE     = 3;
  localparam int LD_DET_EN     = 6;
  localparam int LD_SW_HI      = 5;
  localparam int LD_SW_LO      = 4;
  localparam int LD_SEL        = 3;
  localparam int CC_EN         = 7;
  localparam int CC_TGT_HI     = 6;
  localparam int CC_TGT_LO     = 5;
  localparam int CC_CUR_HI     = 3;
  localparam int CC_CUR_LO     = 0;
  localparam int TC_PRE_HI     = 7;
  localparam int TC_PRE_LO     = 6;
  localparam int TC_MODE       = 4;
  localparam int TC_FAST_HI    = 1;
  localparam int TC_FAST_LO    = 0;

  // reset values
  localparam logic [7:0] RST_LED_DET  = 8'h40;
  localparam logic [7:0] RST_CHG_CTRL = 8'hc8;
  localparam logic [7:0] RST_TMR_CFG  = 8'h41;

  // timing: one prescaler tick is 62.5 ms
  localparam int CLK_PERIOD_NS  = 20;
  localparam int TICK_PERIOD_NS = 62_500_000;
  localparam int TICK_CYCLES    = TICK_PERIOD_NS / CLK_PERIOD_NS;
  localparam int TICKS_PER_MIN  = 960;
  localparam int PRE_MIN_BASE   = 40;
  localparam int PRE_MIN_STEP   = 10;
  localparam int FAST_HR_BASE   = 6;
  localparam int FAST_HR_STEP   = 2;
  localparam int MIN_PER_HR     = 60;

  // blink phase bit pairs within the tick counter (period 2^(n+1) ticks)
  localparam int BLINK_4HZ   = 1;
  localparam int BLINK_2HZ   = 2;
  localparam int BLINK_1HZ   = 3;
  localparam int BLINK_0P5HZ = 4;

  // synchronised analogue comparator inputs
  localparam int NUM_SENSE    = 8;
  localparam int S_VBUS       = 0;
  localparam int S_BAT_LOW    = 1;
  localparam int S_AT_TARGET  = 2;
  localparam int S_BAT_2V2    = 3;
  localparam int S_I_LT10     = 4;
  localparam int S_I_LT20     = 5;
  localparam int S_VBUS_OV    = 6;
  localparam int S_DIE_HOT    = 7;

  // indicator pattern codes
  localparam logic [1:0] LED_HIZ  = 2'h0;
  localparam logic [1:0] LED_SLOW = 2'h1;
  localparam logic [1:0] LED_FAST = 2'h2;
  localparam logic [1:0] LED_LOW  = 2'h3;

  typedef enum logic [2:0] {
    CTLC_IDLE = 3'h0,
    CTLC_PRE  = 3'h1,
    CTLC_FAST = 3'h3,
    CTLC_DONE = 3'h2,
    CTLC_SAFE = 3'h6
  } ctlc_state_e;

endpackage

// File: rtl/ctlc_top.sv
`timescale 1ns/1ps
`default_nettype none
module ctlc_top #(
  parameter int TICK_CYCLES = ctlc_pkg::TICK_CYCLES
) (
  // clock and reset
  input  wire logic        clock_i,
  input  wire logic        rst_i,
  // apb slave
  input  wire logic        psel_i,
  input  wire logic        penable_i,
  input  wire logic        pwrite_i,
  input  wire logic [7:0]  paddr_i,
  input  wire logic [31:0] pwdata_i,
  input  wire logic [3:0]  pstrb_i,
  output logic      [31:0] prdata_o,
  output logic             pready_o,
  output logic             pslverr_o,
  // analogue comparator results
  input  wire logic        vbus_present_i,
  input  wire logic        bat_below_precharge_i,
  input  wire logic        bat_above_target_i,
  input  wire logic        bat_above_detect_i,
  input  wire logic        current_below_10pct_i,
  input  wire logic        current_below_20pct_i,
  input  wire logic        vbus_over_6v3_i,
  input  wire logic        die_over_level2_i,
  // regulation controls
  output logic             charge_active_o,
  output logic             precharge_mode_o,
  output logic             safe_mode_o,
  output logic      [1:0]  charge_target_voltage_o,
  output logic      [3:0]  charge_current_setting_o,
  output logic             detect_probe_o,
  // events
  output logic             safe_exit_event_o,
  output logic             presence_event_o,
  // open-drain indicator
  output logic             charge_indicator_pin_o,
  output logic             charge_indicator_pin_oe_o
);

  localparam logic [22:0] TICK_LAST = 23'(TICK_CYCLES - 1);
  localparam logic [7:0]  PROBE_LAST = 8'hff;

  // writable bits of each control register; the rest read back as zero
  localparam logic [7:0]  WMASK_LED = 8'h78;
  localparam logic [7:0]  WMASK_CHG = 8'hef;
  localparam logic [7:0]  WMASK_TMR = 8'hd3;

  // local names for the package's state codes, nothing is imported
  typedef ctlc_pkg::ctlc_state_e ctlc_state_e;
  localparam ctlc_state_e CTLC_IDLE = ctlc_pkg::CTLC_IDLE;
  localparam ctlc_state_e CTLC_PRE  = ctlc_pkg::CTLC_PRE;
  localparam ctlc_state_e CTLC_FAST = ctlc_pkg::CTLC_FAST;
  localparam ctlc_state_e CTLC_DONE = ctlc_pkg::CTLC_DONE;
  localparam ctlc_state_e CTLC_SAFE = ctlc_pkg::CTLC_SAFE;

  logic [7:0]  led_det;
  logic [7:0]  chg_ctrl;
  logic [7:0]  tmr_cfg;
  logic [7:0]  status;
  logic [ctlc_pkg::NUM_SENSE-1:0] sync1;
  logic [ctlc_pkg::NUM_SENSE-1:0] sync2;
  logic [ctlc_pkg::NUM_SENSE-1:0] sync3;
  logic [ctlc_pkg::NUM_SENSE-1:0] sense;
  logic [22:0] presc;
  logic        tick;
  logic [7:0]  tick_cnt;
  logic [19:0] timer;
  logic [19:0] timer_limit;
  logic        expired;
  logic        timed_out;
  ctlc_state_e state;
  ctlc_state_e next_state;
  logic        present;
  logic [1:0]  led_code;
  logic        led_low;
  logic [5:0]  idx;
  logic        addr_ok;
  logic        wr_en;
  logic [7:0]  rd_byte;
  logic        charging;

  // three-stage synchronisers, value taken once stages two and three agree
  for (genvar g = 0; g < ctlc_pkg::NUM_SENSE; g++) begin : g_sync
    always_ff @(posedge clock_i or posedge rst_i) begin
      if (rst_i) begin
        sync1[g] <= 1'b0;
        sync2[g] <= 1'b0;
        sync3[g] <= 1'b0;
        sense[g] <= 1'b0;
      end else begin
        sync2[g] <= sync1[g];
        sync3[g] <= sync2[g];
        if (sync2[g] == sync3[g]) begin
          sense[g] <= sync3[g];
        end
        case (g)
          ctlc_pkg::S_VBUS:      sync1[g] <= vbus_present_i;
          ctlc_pkg::S_BAT_LOW:   sync1[g] <= bat_below_precharge_i;
          ctlc_pkg::S_AT_TARGET: sync1[g] <= bat_above_target_i;
          ctlc_pkg::S_BAT_2V2:   sync1[g] <= bat_above_detect_i;
          ctlc_pkg::S_I_LT10:    sync1[g] <= current_below_10pct_i;
          ctlc_pkg::S_I_LT20:    sync1[g] <= current_below_20pct_i;
          ctlc_pkg::S_VBUS_OV:   sync1[g] <= vbus_over_6v3_i;
          default:               sync1[g] <= die_over_level2_i;
        endcase
      end
    end
  end

  // free-running prescaler and tick counter
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      presc    <= '0;
      tick     <= 1'b0;
      tick_cnt <= '0;
    end else begin
      tick <= (presc == TICK_LAST);
      if (presc == TICK_LAST) begin
        presc <= '0;
      end else begin
        presc <= presc + 23'h1;
      end
      if (tick) begin
        tick_cnt <= tick_cnt + 8'h1;
      end
    end
  end

  // probe pulse once per tick counter wrap (256 ticks = 16 s)
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      detect_probe_o <= 1'b0;
    end else begin
      detect_probe_o <= tick && (tick_cnt == PROBE_LAST) && sense[ctlc_pkg::S_VBUS];
    end
  end

  // expiry limit in ticks for the current phase
  always_comb begin
    timer_limit = '0;
    if (state == CTLC_PRE) begin
      timer_limit = 20'((ctlc_pkg::PRE_MIN_BASE + ctlc_pkg::PRE_MIN_STEP *
        int'(tmr_cfg[ctlc_pkg::TC_PRE_HI:ctlc_pkg::TC_PRE_LO])) * ctlc_pkg::TICKS_PER_MIN);
    end else begin
      timer_limit = 20'((ctlc_pkg::FAST_HR_BASE + ctlc_pkg::FAST_HR_STEP *
        int'(tmr_cfg[ctlc_pkg::TC_FAST_HI:ctlc_pkg::TC_FAST_LO])) * ctlc_pkg::MIN_PER_HR *
        ctlc_pkg::TICKS_PER_MIN);
    end
  end

  assign expired = (timer >= timer_limit);

  always_comb begin
    next_state = state;
    if (!sense[ctlc_pkg::S_VBUS] || !chg_ctrl[ctlc_pkg::CC_EN]) begin
      next_state = CTLC_IDLE;
    end else begin
      case (state)
        CTLC_IDLE: begin
          next_state = sense[ctlc_pkg::S_BAT_LOW] ? CTLC_PRE : CTLC_FAST;
        end
        CTLC_PRE, CTLC_FAST: begin
          if (sense[ctlc_pkg::S_AT_TARGET] && sense[ctlc_pkg::S_I_LT10]) begin
            next_state = CTLC_DONE;
          end else if (expired) begin
            next_state = CTLC_SAFE;
          end else begin
            next_state = sense[ctlc_pkg::S_BAT_LOW] ? CTLC_PRE : CTLC_FAST;
          end
        end
        CTLC_SAFE: begin
          if (sense[ctlc_pkg::S_AT_TARGET]) begin
            next_state = CTLC_DONE;
          end
        end
        CTLC_DONE: next_state = CTLC_DONE;
        default:   next_state = CTLC_IDLE;
      endcase
    end
  end

  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      state <= CTLC_IDLE;
    end else begin
      state <= next_state;
    end
  end

  // expiry timer, cleared on restart and on phase change, held at low current
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      timer <= '0;
    end else if (next_state != state) begin
      timer <= '0;
    end else if (tick && (state == CTLC_PRE || state == CTLC_FAST) &&
                 !sense[ctlc_pkg::S_I_LT20]) begin
      timer <= timer + 20'h1;
    end
  end

  // timeout alarm stays until the charge is restarted
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      timed_out <= 1'b0;
    end else if (next_state == CTLC_IDLE) begin
      timed_out <= 1'b0;
    end else if (next_state == CTLC_SAFE) begin
      timed_out <= 1'b1;
    end
  end

  assign charging = (state == CTLC_PRE) || (state == CTLC_FAST) || (state == CTLC_SAFE);

  // regulation controls and safe-mode exit event
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      charge_active_o          <= 1'b0;
      precharge_mode_o         <= 1'b0;
      safe_mode_o              <= 1'b0;
      charge_target_voltage_o  <= '0;
      charge_current_setting_o <= '0;
      safe_exit_event_o        <= 1'b0;
    end else begin
      charge_active_o          <= charging;
      precharge_mode_o         <= (state == CTLC_PRE);
      safe_mode_o              <= (state == CTLC_SAFE);
      charge_target_voltage_o  <= chg_ctrl[ctlc_pkg::CC_TGT_HI:ctlc_pkg::CC_TGT_LO];
      charge_current_setting_o <= chg_ctrl[ctlc_pkg::CC_CUR_HI:ctlc_pkg::CC_CUR_LO];
      safe_exit_event_o        <= (state == CTLC_SAFE) && (next_state != CTLC_SAFE);
    end
  end

  // battery presence detection
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      present          <= 1'b0;
      presence_event_o <= 1'b0;
    end else begin
      presence_event_o <= 1'b0;
      if (led_det[ctlc_pkg::LD_DET_EN] && (present != sense[ctlc_pkg::S_BAT_2V2])) begin
        present          <= sense[ctlc_pkg::S_BAT_2V2];
        presence_event_o <= 1'b1;
      end
    end
  end

  // indicator pattern selection
  always_comb begin
    led_code = ctlc_pkg::LED_HIZ;
    if (!led_det[ctlc_pkg::LD_SEL]) begin
      led_code = led_det[ctlc_pkg::LD_SW_HI:ctlc_pkg::LD_SW_LO];
    end else if (!tmr_cfg[ctlc_pkg::TC_MODE]) begin
      if (sense[ctlc_pkg::S_VBUS_OV]) begin
        led_code = ctlc_pkg::LED_FAST;
      end else if (timed_out || sense[ctlc_pkg::S_DIE_HOT]) begin
        led_code = ctlc_pkg::LED_SLOW;
      end else if (charging) begin
        led_code = ctlc_pkg::LED_LOW;
      end
    end else begin
      if (sense[ctlc_pkg::S_VBUS_OV] || timed_out || sense[ctlc_pkg::S_DIE_HOT]) begin
        led_code = ctlc_pkg::LED_FAST;
      end else if (charging) begin
        led_code = ctlc_pkg::LED_SLOW;
      end else if (state == CTLC_DONE) begin
        led_code = ctlc_pkg::LED_LOW;
      end
    end
  end

  // low phase is the last quarter of each blink period
  always_comb begin
    led_low = 1'b0;
    case ({led_det[ctlc_pkg::LD_SEL], led_code})
      {1'b0, ctlc_pkg::LED_SLOW}: led_low = &tick_cnt[ctlc_pkg::BLINK_0P5HZ -: 2];
      {1'b0, ctlc_pkg::LED_FAST}: led_low = &tick_cnt[ctlc_pkg::BLINK_2HZ -: 2];
      {1'b1, ctlc_pkg::LED_SLOW}: led_low = &tick_cnt[ctlc_pkg::BLINK_1HZ -: 2];
      {1'b1, ctlc_pkg::LED_FAST}: led_low = &tick_cnt[ctlc_pkg::BLINK_4HZ -: 2];
      {1'b0, ctlc_pkg::LED_LOW},
      {1'b1, ctlc_pkg::LED_LOW}:  led_low = 1'b1;
      default:                    led_low = 1'b0;
    endcase
  end

  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      charge_indicator_pin_o    <= 1'b0;
      charge_indicator_pin_oe_o <= 1'b0;
    end else begin
      charge_indicator_pin_o    <= 1'b0;
      charge_indicator_pin_oe_o <= led_low;
    end
  end

  // apb decode: one wait state, unmapped or misaligned answers with pslverr
  assign idx     = paddr_i[7:2];
  assign addr_ok = (paddr_i[1:0] == 2'h0) &&
                   ((idx == ctlc_pkg::IDX_STATUS) || (idx == ctlc_pkg::IDX_LED_DET) ||
                    (idx == ctlc_pkg::IDX_CHG_CTRL) || (idx == ctlc_pkg::IDX_TMR_CFG));
  assign wr_en   = psel_i && penable_i && pready_o && pwrite_i && addr_ok && pstrb_i[0];

  assign status = {2'h0, present, 1'b0, (state == CTLC_SAFE), 3'h0};

  always_comb begin
    case (idx)
      ctlc_pkg::IDX_STATUS:   rd_byte = status;
      ctlc_pkg::IDX_LED_DET:  rd_byte = led_det;
      ctlc_pkg::IDX_CHG_CTRL: rd_byte = chg_ctrl;
      ctlc_pkg::IDX_TMR_CFG:  rd_byte = tmr_cfg;
      default:                rd_byte = 8'h00;
    endcase
  end

  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      pready_o  <= 1'b0;
      pslverr_o <= 1'b0;
    end else begin
      pready_o  <= psel_i && penable_i && !pready_o;
      pslverr_o <= psel_i && penable_i && !pready_o && !addr_ok;
    end
  end

  // read data stands only in the answer cycle and is zero otherwise
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      prdata_o <= '0;
    end else if (psel_i && penable_i && !pready_o && !pwrite_i && addr_ok) begin
      prdata_o <= {24'h000000, rd_byte};
    end else begin
      prdata_o <= '0;
    end
  end

  // writable registers; status is read-only
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      led_det  <= ctlc_pkg::RST_LED_DET;
      chg_ctrl <= ctlc_pkg::RST_CHG_CTRL;
      tmr_cfg  <= ctlc_pkg::RST_TMR_CFG;
    end else if (wr_en) begin
      case (idx)
        ctlc_pkg::IDX_LED_DET:  led_det  <= pwdata_i[7:0] & WMASK_LED;
        ctlc_pkg::IDX_CHG_CTRL: chg_ctrl <= pwdata_i[7:0] & WMASK_CHG;
        ctlc_pkg::IDX_TMR_CFG:  tmr_cfg  <= pwdata_i[7:0] & WMASK_TMR;
        default:                led_det  <= led_det;
      endcase
    end
  end

endmodule
`default_nettype wire

// File: testbench/ctlc_top_asserts.sv
`timescale 1ns/1ps
`default_nettype none
module ctlc_top_chk (
  // clock and reset
  input wire logic        clock_i,
  input wire logic        rst_i,
  // apb
  input wire logic        psel_i,
  input wire logic        penable_i,
  input wire logic [31:0] prdata_o,
  input wire logic        pready_o,
  input wire logic        pslverr_o,
  // charger
  input wire logic        vbus_present_i,
  input wire logic        charge_active_o,
  input wire logic        precharge_mode_o,
  input wire logic        safe_mode_o,
  input wire logic        detect_probe_o,
  input wire logic        safe_exit_event_o,
  input wire logic        presence_event_o,
  input wire logic        charge_indicator_pin_o
);
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (rst_i);
  sequence s_access;
    psel_i && penable_i && !pready_o;
  endsequence
  sequence s_bus_gone;
    !vbus_present_i [*8];
  endsequence
  property p_one_wait;
    s_access |=> pready_o;
  endproperty
  property p_ready_pulse;
    pready_o |=> !pready_o;
  endproperty
  property p_err_ready;
    pslverr_o |-> pready_o && psel_i && penable_i;
  endproperty
  property p_rdata_idle;
    !pready_o |-> prdata_o == 32'h0;
  endproperty
  property p_pre_charging;
    precharge_mode_o |-> charge_active_o && !safe_mode_o;
  endproperty
  property p_safe_charging;
    safe_mode_o |-> charge_active_o;
  endproperty
  property p_bus_stop;
    s_bus_gone |-> !charge_active_o && !safe_mode_o;
  endproperty
  property p_exit_event;
    safe_exit_event_o |-> ($past(safe_mode_o) || safe_mode_o) ##1 !safe_exit_event_o;
  endproperty
  property p_presence_pulse;
    presence_event_o |=> !presence_event_o;
  endproperty
  property p_probe_pulse;
    detect_probe_o |=> !detect_probe_o [*8];
  endproperty
  property p_pin_low;
    charge_indicator_pin_o == 1'b0;
  endproperty
  a_one_wait: assert property (p_one_wait) else $error("no answer after one wait");
  a_ready_pulse: assert property (p_ready_pulse) else $error("pready longer than one cycle");
  a_err_ready: assert property (p_err_ready) else $error("pslverr outside answer");
  a_rdata_idle: assert property (p_rdata_idle) else $error("prdata not zero when idle");
  a_pre_charging: assert property (p_pre_charging) else $error("precharge while idle");
  a_safe_charging: assert property (p_safe_charging) else $error("safe mode not charging");
  a_bus_stop: assert property (p_bus_stop) else $error("charging without bus power");
  a_exit_event: assert property (p_exit_event) else $error("bad safe exit event");
  a_presence_pulse: assert property (p_presence_pulse) else $error("long presence event");
  a_probe_pulse: assert property (p_probe_pulse) else $error("probe too long or fast");
  a_pin_low: assert property (p_pin_low) else $error("indicator drives high");
endmodule
`default_nettype wire

// File: testbench/ctlc_analog_model.sv
`timescale 1ns/1ps
`default_nettype none
module ctlc_analog_model #(
  parameter int TGT_BASE_MV = 4100,
  parameter int TGT_STEP_MV = 50
) (
  // bench commands
  input  wire logic       vbus_i,
  input  wire logic       ov_i,
  input  wire logic       hot_i,
  input  var  int         vbat_mv_i,
  input  var  int         cur_pct_i,
  // from the charger control
  input  wire logic       charge_active_i,
  input  wire logic [1:0] target_i,
  // comparator results
  output logic            vbus_present_o,
  output logic            bat_below_precharge_o,
  output logic            bat_above_target_o,
  output logic            bat_above_detect_o,
  output logic            current_below_10pct_o,
  output logic            current_below_20pct_o,
  output logic            vbus_over_6v3_o,
  output logic            die_over_level2_o
);
  int meas;
  // no current flows while the charger is off
  assign meas = charge_active_i ? cur_pct_i : 0;
  assign vbus_present_o = vbus_i;
  assign bat_below_precharge_o = vbat_mv_i < 3000;
  assign bat_above_target_o = vbat_mv_i > TGT_BASE_MV + TGT_STEP_MV * int'(target_i) - 100;
  assign bat_above_detect_o = vbat_mv_i > 2200;
  assign current_below_10pct_o = meas < 10;
  assign current_below_20pct_o = meas < 20;
  assign vbus_over_6v3_o = ov_i;
  assign die_over_level2_o = hot_i;
endmodule
`default_nettype wire

// File: testbench/tb.sv
`timescale 1ns/1ps
`default_nettype none
module tb;
  localparam int TC = 2;
  logic        clock_i, rst_i, psel_i, penable_i, pwrite_i, pready_o, pslverr_o;
  logic [7:0]  paddr_i;
  logic [31:0] pwdata_i, prdata_o, r;
  logic [3:0]  pstrb_i;
  logic        vbus_present_i, bat_below_precharge_i, bat_above_target_i, bat_above_detect_i;
  logic        current_below_10pct_i, current_below_20pct_i, vbus_over_6v3_i, die_over_level2_i;
  logic        charge_active_o, precharge_mode_o, safe_mode_o, detect_probe_o;
  logic [1:0]  charge_target_voltage_o;
  logic [3:0]  charge_current_setting_o;
  logic        safe_exit_event_o, presence_event_o, charge_indicator_pin_o;
  logic        charge_indicator_pin_oe_o, e, seen, vbus_c, ov_c, hot_c;
  int          vbat_c, cur_c, mismatches, n_tests, cyc, n;
  ctlc_top #(.TICK_CYCLES(TC)) i_ctlc_top (.*);
  ctlc_analog_model i_ctlc_analog_model (
    .vbus_i(vbus_c), .ov_i(ov_c), .hot_i(hot_c), .vbat_mv_i(vbat_c), .cur_pct_i(cur_c),
    .charge_active_i(charge_active_o), .target_i(charge_target_voltage_o),
    .vbus_present_o(vbus_present_i), .bat_below_precharge_o(bat_below_precharge_i),
    .bat_above_target_o(bat_above_target_i), .bat_above_detect_o(bat_above_detect_i),
    .current_below_10pct_o(current_below_10pct_i), .current_below_20pct_o(current_below_20pct_i),
    .vbus_over_6v3_o(vbus_over_6v3_i), .die_over_level2_o(die_over_level2_i));
  initial begin
    clock_i = 1'b0;
    forever #10 clock_i = ~clock_i;
  end
  function automatic logic [7:0] ad(input logic [5:0] i);
    return {i, 2'b00};
  endfunction
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      mismatches++;
    end
  endtask
  task automatic conclude;
    $display("comparisons %0d mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  // one apb transfer; waits for pready, the global timeout ends a hang
  task automatic apb(input logic w, input logic [7:0] a, input logic [7:0] d);
    @(posedge clock_i);
    psel_i <= 1'b1;
    pwrite_i <= w;
    paddr_i <= a;
    pwdata_i <= {24'h0, d};
    @(posedge clock_i);
    penable_i <= 1'b1;
    do @(posedge clock_i); while (pready_o !== 1'b1);
    r = prdata_o;
    e = pslverr_o;
    psel_i <= 1'b0;
    penable_i <= 1'b0;
  endtask
  task automatic wait_ev(ref logic s);
    seen = 1'b0;
    repeat (20) begin
      @(posedge clock_i);
      if (s === 1'b1) seen = 1'b1;
    end
  endtask
  task automatic t_regs;
    apb(1'b0, ad(ctlc_pkg::IDX_LED_DET), 8'h0);
    chk(r, 32'h40);
    apb(1'b0, ad(ctlc_pkg::IDX_TMR_CFG), 8'h0);
    chk(r, 32'h41);
    chk({charge_target_voltage_o, charge_current_setting_o}, 6'h28);
    apb(1'b1, ad(ctlc_pkg::IDX_TMR_CFG), 8'hff);
    apb(1'b0, ad(ctlc_pkg::IDX_TMR_CFG), 8'h0);
    chk(r, 32'hd3);
    apb(1'b1, ad(ctlc_pkg::IDX_STATUS), 8'hff);
    chk(e, 1'b0);
    apb(1'b0, ad(ctlc_pkg::IDX_STATUS), 8'h0);
    chk(r[3], 1'b0);
    apb(1'b0, ad(6'h10), 8'h0);
    chk(e, 1'b1);
    chk(r, 32'h0);
    apb(1'b1, ad(ctlc_pkg::IDX_TMR_CFG), 8'h00);
    $display("test regs done");
  endtask
  task automatic t_charge;
    repeat (10) @(posedge clock_i);
    chk({charge_active_o, precharge_mode_o}, 2'b10);
    vbat_c <= 2800;
    repeat (10) @(posedge clock_i);
    chk({charge_active_o, precharge_mode_o}, 2'b11);
    vbat_c <= 4500;
    cur_c <= 5;
    repeat (10) @(posedge clock_i);
    chk(charge_active_o, 1'b0);
    vbat_c <= 3500;
    cur_c <= 50;
    apb(1'b1, ad(ctlc_pkg::IDX_CHG_CTRL), 8'h48);
    apb(1'b1, ad(ctlc_pkg::IDX_CHG_CTRL), 8'hc8);
    repeat (10) @(posedge clock_i);
    chk(charge_active_o, 1'b1);
    $display("test charge done");
  endtask
  task automatic t_timeout;
    vbat_c <= 2800;
    n = 0;
    while (precharge_mode_o !== 1'b1 && n < 20) begin
      @(posedge clock_i);
      n++;
    end
    n = 0;
    repeat (1000) @(posedge clock_i);
    cur_c <= 10;
    repeat (1000) @(posedge clock_i);
    cur_c <= 50;
    while (safe_mode_o !== 1'b1 && n < 80000) begin
      @(posedge clock_i);
      n++;
    end
    // n starts after 2000 cycles, 1000 of them paused
    chk(n >= 40 * 960 * TC - 1000 - 20 && n <= 40 * 960 * TC - 1000 + 20, 1'b1);
    chk({charge_active_o, precharge_mode_o}, 2'b10);
    apb(1'b0, ad(ctlc_pkg::IDX_STATUS), 8'h0);
    chk(r[3], 1'b1);
    vbat_c <= 4500;
    wait_ev(safe_exit_event_o);
    chk({seen, safe_mode_o}, 2'b10);
    $display("test timeout done");
  endtask
  task automatic led(input logic [7:0] c32, input logic [7:0] c34, input logic ov,
                     input logic hot, input logic vb, input int eh, input int ee);
    int hi;
    int ed;
    logic prev;
    apb(1'b1, ad(ctlc_pkg::IDX_LED_DET), c32);
    apb(1'b1, ad(ctlc_pkg::IDX_TMR_CFG), c34);
    ov_c <= ov;
    hot_c <= hot;
    vbus_c <= vb;
    repeat (12) @(posedge clock_i);
    hi = 0;
    ed = 0;
    prev = charge_indicator_pin_oe_o;
    repeat (64) begin
      @(posedge clock_i);
      hi += charge_indicator_pin_oe_o;
      ed += charge_indicator_pin_oe_o && !prev;
      prev = charge_indicator_pin_oe_o;
    end
    chk({hi[7:0], ed[7:0]}, {eh[7:0], ee[7:0]});
  endtask
  task automatic t_led;
    vbat_c <= 3500;
    apb(1'b1, ad(ctlc_pkg::IDX_CHG_CTRL), 8'h48);
    apb(1'b1, ad(ctlc_pkg::IDX_CHG_CTRL), 8'hc8);
    led(8'h40, 8'h00, 1'b0, 1'b0, 1'b1, 0, 0);
    led(8'h50, 8'h00, 1'b0, 1'b0, 1'b1, 16, 1);
    led(8'h60, 8'h00, 1'b0, 1'b0, 1'b1, 16, 4);
    led(8'h70, 8'h00, 1'b0, 1'b0, 1'b1, 64, 0);
    led(8'h48, 8'h00, 1'b0, 1'b0, 1'b1, 64, 0);
    led(8'h48, 8'h00, 1'b0, 1'b1, 1'b1, 16, 2);
    led(8'h48, 8'h00, 1'b1, 1'b0, 1'b1, 16, 8);
    led(8'h48, 8'h10, 1'b1, 1'b0, 1'b1, 16, 8);
    led(8'h48, 8'h10, 1'b0, 1'b0, 1'b1, 16, 2);
    led(8'h48, 8'h10, 1'b0, 1'b0, 1'b0, 0, 0);
    led(8'h48, 8'h00, 1'b0, 1'b0, 1'b0, 0, 0);
    $display("test indicator done");
  endtask
  task automatic t_detect;
    vbus_c <= 1'b1;
    vbat_c <= 2000;
    wait_ev(presence_event_o);
    apb(1'b0, ad(ctlc_pkg::IDX_STATUS), 8'h0);
    chk({seen, r[5]}, 2'b10);
    vbat_c <= 3500;
    wait_ev(presence_event_o);
    apb(1'b0, ad(ctlc_pkg::IDX_STATUS), 8'h0);
    chk({seen, r[5]}, 2'b11);
    n = 0;
    repeat (256 * TC) begin
      @(posedge clock_i);
      n += detect_probe_o;
    end
    chk(n, 1);
    apb(1'b1, ad(ctlc_pkg::IDX_LED_DET), 8'h00);
    vbat_c <= 2000;
    wait_ev(presence_event_o);
    chk(seen, 1'b0);
    $display("test detect done");
  endtask
  always @(posedge clock_i) begin
    cyc++;
    if (cyc == 90000) begin
      mismatches++;
      conclude();
    end
  end
  initial begin
    {psel_i, penable_i, pwrite_i, paddr_i, pwdata_i} = '0;
    pstrb_i = 4'hf;
    {ov_c, hot_c} = 2'b00;
    vbus_c = 1'b1;
    vbat_c = 3500;
    cur_c = 50;
    rst_i = 1'b1;
    repeat (3) @(posedge clock_i);
    rst_i <= 1'b0;
    t_regs();
    t_charge();
    t_timeout();
    t_led();
    t_detect();
    conclude();
  end
endmodule
bind ctlc_top ctlc_top_chk i_ctlc_top_chk (.clock_i, .rst_i, .psel_i, .penable_i, .prdata_o,
  .pready_o, .pslverr_o, .vbus_present_i, .charge_active_o, .precharge_mode_o, .safe_mode_o,
  .detect_probe_o, .safe_exit_event_o, .presence_event_o, .charge_indicator_pin_o);
`default_nettype wire
